// >>> cfg_link_pkg.sv
// shared constants for the two-wire configuration link and the synthesizer core
// assumes both ends import it; no timescale, definitions only
package cfg_link_pkg;

  // frame layout, positions counted from zero
  localparam int unsigned FRAME_BYTES   = 11;        // address + cmd + count + 8 data
  localparam int unsigned BITS_PER_SLOT = 9;         // eight data bits then acknowledge
  localparam logic [7:0]  SLAVE_ADDR    = 8'hd2;     // 1101_0010, write direction
  localparam logic [3:0]  CMD_POS       = 4'h1;      // command code, discarded
  localparam logic [3:0]  COUNT_POS     = 4'h2;      // byte count, discarded
  localparam logic [3:0]  DATA_FIRST    = 4'h3;      // data byte zero
  localparam logic [3:0]  DATA_LAST     = 4'h8;      // data byte five
  localparam logic [3:0]  STOP_POS      = 4'hb;      // extra clock edge of the stop
  localparam int unsigned CFG_BYTES     = 6;         // loaded configuration bytes

  // field positions in the configuration bytes
  localparam int unsigned SPREAD_BYTE   = 0;         // bits 1..0 spread mode
  localparam int unsigned SPREAD_EN_BIT = 0;         // modulation on
  localparam int unsigned SPREAD_WIDE   = 1;         // doubled deviation
  localparam int unsigned FSEL_LSB      = 4;         // bits 7..4 frequency select
  localparam int unsigned OUT_EN_BYTE   = 1;         // one enable bit per output
  localparam int unsigned MODE_BYTE     = 2;
  localparam int unsigned TRISTATE_BIT  = 0;         // outputs high impedance
  localparam int unsigned TEST_BIT      = 1;         // pll bypass

  // reset values of the configuration bytes
  localparam logic [7:0]  CFG0_RESET    = 8'h00;     // spread off, select 0
  localparam logic [7:0]  CFG1_RESET    = 8'h0f;     // all outputs running
  localparam logic [7:0]  CFG2_RESET    = 8'h00;     // driven, pll in use
  localparam logic [7:0]  CFG3_RESET    = 8'h00;
  localparam logic [7:0]  CFG4_RESET    = 8'h00;
  localparam logic [7:0]  CFG5_RESET    = 8'h00;

  // synthesizer figures
  localparam logic [15:0] BASE_WORD     = 16'h1000;  // phase step at select 0
  localparam logic [15:0] FSEL_STEP     = 16'h0100;  // phase step per select code
  localparam int unsigned SLEW_DIV      = 16;        // cycles per one-unit slew
  localparam int unsigned SPREAD_DIV    = 8;         // cycles per profile step
  localparam logic [15:0] SPREAD_DEPTH  = 16'h0040;  // triangle peak, narrow mode

  // host side: command byte and count byte it sends
  localparam logic [7:0]  CMD_CODE      = 8'h00;
  localparam logic [7:0]  BYTE_COUNT    = 8'h08;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_BITS  = 3'b010,
    H_STOP  = 3'b011,
    H_DONE  = 3'b100
  } host_state_e;

endpackage

// >>> cfg_link_if.sv
// open-drain two-wire link between the chipset host and the clock device
// assumes the host makes the clock line; data line pulled high when no one drives
`timescale 1ns/1ps
interface cfg_link_if;
  logic serial_clock_pin;  // link clock, driven by the host
  logic sda_host_lvl;      // host data value when driving
  logic sda_host_oe;       // host drives the data line
  logic sda_dev_lvl;       // device data value when driving
  logic sda_dev_oe;        // device drives the data line
  logic serial_data_pin;   // resolved wire level

  // wired-and with pull-up
  assign serial_data_pin = !((sda_host_oe && !sda_host_lvl) || (sda_dev_oe && !sda_dev_lvl));

  modport host (
    output serial_clock_pin,
    output sda_host_lvl,
    output sda_host_oe,
    input  serial_data_pin
  );

  modport device (
    input  serial_clock_pin,
    output sda_dev_lvl,
    output sda_dev_oe,
    input  serial_data_pin
  );
endinterface

// >>> clock_config_device.sv
// clock device end: write-only link receiver plus the synthesizer it steers
// assumes serial_clock_pin only toggles during frames; ref_clk is the reference input
`timescale 1ns/1ps
module clock_config_device
  import cfg_link_pkg::*;
#(
  parameter int unsigned N_OUT = 4  // number of clock outputs
) (
  input  wire logic            ref_clk,
  input  wire logic            reset,
  cfg_link_if.device           link,
  output logic [N_OUT-1:0]     clk_out,
  output logic [N_OUT-1:0]     clk_out_oe,
  output logic [15:0]          freq_word,
  output logic                 spread_modulation
);
  import cfg_link_pkg::*;

  // ---------------- link clock domain ----------------
  logic [3:0]  bit_ff;                 // slot bit index, 8 is acknowledge
  logic [3:0]  byte_ff;                // byte position in frame
  logic [7:0]  shift_ff;               // incoming byte
  logic        addr_ok_ff;             // address matched this frame
  logic [7:0]  lcfg_ff [CFG_BYTES];    // configuration as received
  logic        upd_tgl_ff;             // flips on every loaded byte
  logic        ack_oe_ff;              // acknowledge drive
  logic [7:0]  nxt_shift;              // byte including current bit

  assign nxt_shift = {shift_ff[6:0], link.serial_data_pin};

  // bit and byte position, advanced on each rising link edge
  always_ff @(posedge link.serial_clock_pin or posedge reset) begin
    if (reset) begin
      bit_ff  <= 4'h0;
      byte_ff <= 4'h0;
    end else if (byte_ff == STOP_POS) begin  // stop edge closes the frame
      bit_ff  <= 4'h0;
      byte_ff <= 4'h0;
    end else if (bit_ff == 4'(BITS_PER_SLOT - 1)) begin
      bit_ff  <= 4'h0;
      byte_ff <= byte_ff + 4'h1;
    end else begin
      bit_ff  <= bit_ff + 4'h1;
    end
  end

  // data line is set while the clock is low, so it is stable at the rising edge
  always_ff @(posedge link.serial_clock_pin or posedge reset) begin
    if (reset) begin
      shift_ff <= 8'h00;
    end else if (bit_ff < 4'h8) begin
      shift_ff <= nxt_shift;
    end
  end

  // address check on the last bit of the first byte
  always_ff @(posedge link.serial_clock_pin or posedge reset) begin
    if (reset) begin
      addr_ok_ff <= 1'b0;
    end else if (byte_ff == 4'h0 && bit_ff == 4'h7) begin
      addr_ok_ff <= (nxt_shift == SLAVE_ADDR);
    end else if (byte_ff == STOP_POS) begin
      addr_ok_ff <= 1'b0;
    end
  end

  // configuration bytes, loaded as each byte completes
  for (genvar g = 0; g < CFG_BYTES; g++) begin : g_lcfg
    localparam logic [7:0] RST = (g == 0) ? CFG0_RESET : (g == 1) ? CFG1_RESET :
                                 (g == 2) ? CFG2_RESET : (g == 3) ? CFG3_RESET :
                                 (g == 4) ? CFG4_RESET : CFG5_RESET;
    always_ff @(posedge link.serial_clock_pin or posedge reset) begin
      if (reset) begin
        lcfg_ff[g] <= RST;
      end else if (addr_ok_ff && bit_ff == 4'h7 &&
                   byte_ff == DATA_FIRST + 4'(g)) begin
        lcfg_ff[g] <= nxt_shift;
      end
    end
  end
  // positions CMD_POS, COUNT_POS and those past DATA_LAST match no entry above

  // announce each loaded byte to the reference domain
  always_ff @(posedge link.serial_clock_pin or posedge reset) begin
    if (reset) begin
      upd_tgl_ff <= 1'b0;
    end else if (addr_ok_ff && bit_ff == 4'h7 &&
                 byte_ff >= DATA_FIRST && byte_ff <= DATA_LAST) begin
      upd_tgl_ff <= ~upd_tgl_ff;
    end
  end

  // acknowledge: pull low from the falling edge before the ninth clock
  always_ff @(negedge link.serial_clock_pin or posedge reset) begin
    if (reset) begin
      ack_oe_ff <= 1'b0;
    end else begin
      ack_oe_ff <= addr_ok_ff && (bit_ff == 4'h8);
    end
  end

  // only ever pulls low for acknowledge; no read path exists
  assign link.sda_dev_lvl = 1'b0;
  assign link.sda_dev_oe  = ack_oe_ff;

  // ---------------- reference domain ----------------
  logic        tgl_s1_ff;              // first synchroniser stage
  logic        tgl_s2_ff;              // second synchroniser stage
  logic        tgl_seen_ff;            // last toggle value acted on
  logic [7:0]  cfg_ff [CFG_BYTES];     // configuration in use
  logic [15:0] target_word;            // frequency picked by select
  logic [15:0] cur_word_ff;            // slewed frequency
  logic [7:0]  slew_cnt_ff;            // slew pacing
  logic [7:0]  spr_cnt_ff;             // profile pacing
  logic [15:0] tri_ff;                 // triangle deviation
  logic        tri_up_ff;              // triangle direction
  logic [15:0] tri_peak;               // peak for current mode
  logic [15:0] phase_ff;               // synthesizer phase accumulator
  logic        ref_half_ff;            // reference clock divided by two
  logic [15:0] freq_word_ff;           // step actually applied
  logic        spread_ff;              // spreading active

  // toggle crossing; data is loaded on the same link edge as the toggle and then holds for the nine link clocks of a slot
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tgl_s1_ff   <= 1'b0;
      tgl_s2_ff   <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_s1_ff   <= upd_tgl_ff;
      tgl_s2_ff   <= tgl_s1_ff;
      tgl_seen_ff <= tgl_s2_ff;
    end
  end

  // copy configuration on each announced change
  for (genvar g = 0; g < CFG_BYTES; g++) begin : g_cfg
    localparam logic [7:0] RST = (g == 0) ? CFG0_RESET : (g == 1) ? CFG1_RESET :
                                 (g == 2) ? CFG2_RESET : (g == 3) ? CFG3_RESET :
                                 (g == 4) ? CFG4_RESET : CFG5_RESET;
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        cfg_ff[g] <= RST;
      end else if (tgl_s2_ff != tgl_seen_ff) begin
        cfg_ff[g] <= lcfg_ff[g];
      end
    end
  end

  assign target_word = BASE_WORD + 16'(cfg_ff[SPREAD_BYTE][7:FSEL_LSB]) * FSEL_STEP;

  // slew one unit at a time toward the selected frequency
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur_word_ff <= BASE_WORD;
      slew_cnt_ff <= 8'h00;
    end else if (slew_cnt_ff == 8'(SLEW_DIV - 1)) begin
      slew_cnt_ff <= 8'h00;
      if (cur_word_ff < target_word) begin
        cur_word_ff <= cur_word_ff + 16'h0001;
      end else if (cur_word_ff > target_word) begin
        cur_word_ff <= cur_word_ff - 16'h0001;
      end
    end else begin
      slew_cnt_ff <= slew_cnt_ff + 8'h01;
    end
  end

  assign tri_peak = cfg_ff[SPREAD_BYTE][SPREAD_WIDE] ? {SPREAD_DEPTH[14:0], 1'b0}
                                                     : SPREAD_DEPTH;

  // triangle deviation profile, held at zero when spreading is off
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tri_ff     <= 16'h0000;
      tri_up_ff  <= 1'b1;
      spr_cnt_ff <= 8'h00;
    end else if (!cfg_ff[SPREAD_BYTE][SPREAD_EN_BIT]) begin
      tri_ff     <= 16'h0000;
      tri_up_ff  <= 1'b1;
      spr_cnt_ff <= 8'h00;
    end else if (spr_cnt_ff == 8'(SPREAD_DIV - 1)) begin
      spr_cnt_ff <= 8'h00;
      if (tri_up_ff) begin
        tri_ff    <= tri_ff + 16'h0001;
        tri_up_ff <= (tri_ff + 16'h0001) < tri_peak;
      end else begin
        tri_ff    <= tri_ff - 16'h0001;
        tri_up_ff <= (tri_ff - 16'h0001) == 16'h0000;
      end
    end else begin
      spr_cnt_ff <= spr_cnt_ff + 8'h01;
    end
  end

  // phase accumulator, deviation subtracted so spreading goes downward
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      freq_word_ff <= BASE_WORD;
      phase_ff     <= 16'h0000;
      spread_ff    <= 1'b0;
    end else begin
      freq_word_ff <= cur_word_ff - tri_ff;
      phase_ff     <= phase_ff + freq_word_ff;
      spread_ff    <= cfg_ff[SPREAD_BYTE][SPREAD_EN_BIT];
    end
  end

  // reference divided by two: one level change per rising reference edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ref_half_ff <= 1'b0;
    end else begin
      ref_half_ff <= ~ref_half_ff;
    end
  end

  // per output: test, disable and three-state selection
  for (genvar i = 0; i < N_OUT; i++) begin : g_out
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        clk_out[i]    <= 1'b0;
        clk_out_oe[i] <= 1'b1;
      end else begin
        if (cfg_ff[MODE_BYTE][TEST_BIT]) begin
          clk_out[i] <= ref_half_ff;
        end else if (cfg_ff[OUT_EN_BYTE][i]) begin
          clk_out[i] <= phase_ff[15];
        end else begin
          clk_out[i] <= 1'b0;
        end
        clk_out_oe[i] <= ~cfg_ff[MODE_BYTE][TRISTATE_BIT];
      end
    end
  end

  assign freq_word         = freq_word_ff;
  assign spread_modulation = spread_ff;

endmodule

// >>> clock_config_host.sv
// chipset end: sends one eleven-byte configuration frame on request
// assumes ref_clk domain; link clock is made here by a divider
`timescale 1ns/1ps
module clock_config_host
  import cfg_link_pkg::*;
#(
  parameter int unsigned QDIV = 8  // ref cycles per quarter of a link clock
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  cfg_link_if.host         link,
  input  wire logic        send,       // one-cycle request
  input  wire logic [7:0]  addr,       // address byte to send
  input  wire logic [47:0] data,       // data bytes 0..5, byte 0 in [7:0]
  output logic             busy,
  output logic             done,       // one-cycle pulse at frame end
  output logic             nack        // address not acknowledged
);
  import cfg_link_pkg::*;

  host_state_e state_ff;             // sequencer state
  logic [7:0]  qcnt_ff;              // quarter period counter
  logic [1:0]  quarter_ff;           // quarter within a bit
  logic [3:0]  bit_ff;               // bit in slot, 8 is acknowledge
  logic [3:0]  byte_ff;              // byte position
  logic [87:0] frame_ff;             // whole frame, first byte on top
  logic        scl_ff;               // link clock drive
  logic        sda_oe_ff;            // pull data low
  logic        busy_ff;
  logic        done_ff;
  logic        nack_ff;
  logic        sda_s1_ff;            // first synchroniser stage
  logic        sda_s2_ff;            // second synchroniser stage
  logic        tick;                 // quarter boundary
  logic [7:0]  cur_byte;             // byte in flight

  assign tick     = (qcnt_ff == 8'(QDIV - 1));
  assign cur_byte = frame_ff[87 - 8*byte_ff -: 8];

  // data line input synchroniser
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end else begin
      sda_s1_ff <= link.serial_data_pin;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  // quarter period divider, runs only while busy
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      qcnt_ff <= 8'h00;
    end else if (state_ff == H_IDLE || tick) begin
      qcnt_ff <= 8'h00;
    end else begin
      qcnt_ff <= qcnt_ff + 8'h01;
    end
  end

  // frame sequencer: start, 99 clocks, stop edge and release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff   <= H_IDLE;
      quarter_ff <= 2'h0;
      bit_ff     <= 4'h0;
      byte_ff    <= 4'h0;
      frame_ff   <= '0;
      scl_ff     <= 1'b1;
      sda_oe_ff  <= 1'b0;
      nack_ff    <= 1'b0;
    end else begin
      unique case (state_ff)
        H_IDLE: begin
          if (send) begin
            frame_ff <= {addr, CMD_CODE, BYTE_COUNT, data[7:0], data[15:8],
                         data[23:16], data[31:24], data[39:32], data[47:40],
                         8'h00, 8'h00};
            state_ff <= H_START;
            sda_oe_ff <= 1'b1;  // data falls while clock high
          end
        end
        H_START: begin
          if (tick) begin
            scl_ff     <= 1'b0;
            quarter_ff <= 2'h0;
            bit_ff     <= 4'h0;
            byte_ff    <= 4'h0;
            state_ff   <= H_BITS;
          end
        end
        H_BITS: begin
          if (tick) begin
            quarter_ff <= quarter_ff + 2'h1;
            unique case (quarter_ff)
              2'h0: sda_oe_ff <= (bit_ff == 4'h8) ? 1'b0 : ~cur_byte[7 - bit_ff[2:0]];
              2'h1: scl_ff <= 1'b1;
              2'h2: if (bit_ff == 4'h8 && byte_ff == 4'h0) nack_ff <= sda_s2_ff;
              2'h3: begin
                scl_ff <= 1'b0;
                if (bit_ff == 4'h8) begin
                  bit_ff <= 4'h0;
                  if (byte_ff == 4'(FRAME_BYTES - 1)) begin
                    state_ff  <= H_STOP;
                    sda_oe_ff <= 1'b1;
                  end else begin
                    byte_ff <= byte_ff + 4'h1;
                  end
                end else begin
                  bit_ff <= bit_ff + 4'h1;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            if (!scl_ff) begin
              scl_ff <= 1'b1;  // stop edge
            end else begin
              sda_oe_ff <= 1'b0;  // data rises while clock high
              state_ff  <= H_DONE;
            end
          end
        end
        H_DONE: state_ff <= H_IDLE;
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // status outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != H_IDLE && state_ff != H_DONE) || send;
      done_ff <= (state_ff == H_DONE);
    end
  end

  assign link.serial_clock_pin = scl_ff;
  assign link.sda_host_lvl     = 1'b0;
  assign link.sda_host_oe      = sda_oe_ff;
  assign busy                  = busy_ff;
  assign done                  = done_ff;
  assign nack                  = nack_ff;

endmodule

// >>> cfg_link_asserts.sv
// checker: protocol watch on the two-wire configuration link
// assumes a host quarter divider of 2 ref_clk cycles and pulled-up data
`timescale 1ns/1ps
module cfg_link_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serial_clock_pin,
  input wire logic sda_host_lvl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_lvl,
  input wire logic sda_dev_oe,
  input wire logic serial_data_pin
);
  import cfg_link_pkg::*;
  logic [6:0] rise_cnt_ff;  // clock rises since start
  logic [7:0] shift_ff;     // bits seen so far
  logic [7:0] addr_ff;      // address byte of frame
  logic       scl_q_ff;     // previous clock level
  logic       sda_q_ff;     // previous data level
  wire rise_w  = serial_clock_pin && !scl_q_ff;
  wire start_w = sda_q_ff && !serial_data_pin && scl_q_ff && serial_clock_pin;
  wire stop_w  = !sda_q_ff && serial_data_pin && scl_q_ff && serial_clock_pin;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // line history, idle high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= serial_clock_pin;
      sda_q_ff <= serial_data_pin;
    end
  end
  // rise count and address capture
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rise_cnt_ff <= 7'h00;
      shift_ff    <= 8'h00;
      addr_ff     <= 8'h00;
    end else if (start_w) begin
      rise_cnt_ff <= 7'h00;
    end else if (rise_w) begin
      rise_cnt_ff <= rise_cnt_ff + 7'h01;
      shift_ff    <= {shift_ff[6:0], serial_data_pin};
      if (rise_cnt_ff == 7'h07) begin
        addr_ff <= {shift_ff[6:0], serial_data_pin};
      end
    end
  end
  dev_pull_only_a: assert property (sda_dev_oe
    |-> !sda_dev_lvl && addr_ff == SLAVE_ADDR)
    else $error("device drives data high or unaddressed");
  ack_on_low_a: assert property ($rose(sda_dev_oe) |-> !serial_clock_pin)
    else $error("acknowledge starts with clock high");
  ack_slot_a: assert property ($rose(sda_dev_oe) |-> rise_cnt_ff % 9 == 8)
    else $error("device drives outside acknowledge slot");
  ack_length_a: assert property ($rose(sda_dev_oe)
    |-> sda_dev_oe[*7] ##[1:2] !sda_dev_oe)
    else $error("acknowledge length wrong");
  ack_match_a: assert property (rise_w && rise_cnt_ff % 9 == 8
    && rise_cnt_ff < 99 |-> !serial_data_pin == (addr_ff == SLAVE_ADDR))
    else $error("acknowledge disagrees with address");
  frame_len_a: assert property (stop_w |-> rise_cnt_ff == 7'd100)
    else $error("frame clock count wrong");
  bit_stable_a: assert property (rise_w |-> $stable(serial_data_pin) [*2])
    else $error("data moved with clock high");
  clk_high_a: assert property (rise_w |-> serial_clock_pin[*4])
    else $error("clock high phase short");
  clk_low_a: assert property ($fell(serial_clock_pin) |-> (!serial_clock_pin)[*2])
    else $error("clock low phase short");
endmodule

// >>> tb.sv
// testbench: host and device joined by the link, random frames with corners
// assumes the design files and cfg_link_asserts are compiled first
`timescale 1ns/1ps
module tb;
  import cfg_link_pkg::*;
  logic        ref_clk = 1'b0;         // 250 MHz
  logic        reset = 1'b1;           // held 10 cycles
  logic        send = 1'b0;            // frame request
  logic [7:0]  addr = 8'h00;           // address to send
  logic [47:0] data = 48'h0;           // data bytes 0..5
  logic        busy, done, nack, spread_modulation;
  logic [3:0]  clk_out, clk_out_oe;
  logic [15:0] freq_word, prev_word;
  logic [1:0]  spread_hist;            // spread flag history
  logic [31:0] lfsr = 32'h800e;        // random state
  int          n_fail = 0;
  int          total_checks = 0;
  cfg_link_if link_if ();
  clock_config_device #(.N_OUT(4)) clock_config_device_inst (.ref_clk(ref_clk), .reset(reset),
    .link(link_if.device), .clk_out(clk_out), .clk_out_oe(clk_out_oe), .freq_word(freq_word),
    .spread_modulation(spread_modulation));
  clock_config_host #(.QDIV(2)) clock_config_host_inst (.ref_clk(ref_clk), .reset(reset),
    .link(link_if.host), .send(send), .addr(addr), .data(data), .busy(busy), .done(done),
    .nack(nack));
  cfg_link_asserts cfg_link_asserts_inst (.ref_clk(ref_clk), .reset(reset),
    .serial_clock_pin(link_if.serial_clock_pin), .sda_host_lvl(link_if.sda_host_lvl),
    .sda_host_oe(link_if.sda_host_oe), .sda_dev_lvl(link_if.sda_dev_lvl),
    .sda_dev_oe(link_if.sda_dev_oe), .serial_data_pin(link_if.serial_data_pin));
  // clock
  always #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // settled frequency word for a configuration
  function automatic logic [15:0] target(input logic [47:0] c);
    return BASE_WORD + FSEL_STEP * {12'h000, c[7:4]};
  endfunction
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one frame, wait for done under a bound
  task automatic send_frame(input logic [7:0] a, input logic [47:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    addr <= a;
    data <= d;
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    #1;
    check(busy === 1'b1, "busy not raised");
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 2000);
    check(k < 2000, "frame never finished");
    check(busy === 1'b0, "busy after frame end");
    check(nack === (a != SLAVE_ADDR), "acknowledge wrong");
  endtask
  // outputs against configuration
  task automatic check_cfg(input logic [47:0] c);
    logic [15:0] lo, hi;
    logic [3:0]  v, tog;
    lo = 16'hffff;
    hi = 16'h0000;
    tog = 4'h0;
    repeat (8) @(posedge ref_clk);
    #1;
    check(spread_modulation === c[0], "spread enable");
    check(clk_out_oe === {4{~c[16]}}, "three-state");
    if (!c[17]) check((clk_out & ~c[11:8]) === 4'h0, "disabled output not low");
    v = clk_out;
    @(posedge ref_clk);
    #1;
    if (c[17]) check(((clk_out ^ v) & c[11:8]) === c[11:8], "no reference follow");
    repeat (4200) @(posedge ref_clk);
    repeat (64) begin
      @(posedge ref_clk);
      #1;
      if (freq_word < lo) lo = freq_word;
      if (freq_word > hi) hi = freq_word;
      tog = tog | (clk_out ^ v);
      v = clk_out;
    end
    if (!c[17]) check(tog === c[11:8], "enabled outputs not running");
    if (!c[0]) check(lo === target(c) && hi === target(c), "frequency off");
    else check(hi != lo && hi - lo <= (c[1] ? 16'h0100 : 16'h0080), "spread");
  endtask
  // slew watch while spreading stays off
  always @(posedge ref_clk) begin
    prev_word <= freq_word;
    spread_hist <= {spread_hist[0], spread_modulation};
    if (!reset && spread_hist === 2'b00 && !spread_modulation && freq_word !== prev_word) begin
      check(freq_word - prev_word == 1 || prev_word - freq_word == 1, "freq jump");
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    logic [47:0] cfg, d;
    logic [7:0]  a;
    int          i;
    cfg = {CFG5_RESET, CFG4_RESET, CFG3_RESET, CFG2_RESET, CFG1_RESET, CFG0_RESET};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(clk_out_oe === 4'hf && freq_word === BASE_WORD, "reset values");
    check_cfg(cfg);
    for (i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      d = {24'h0, 6'h0, lfsr[7:6], 4'h0, lfsr[5:2], 3'h0, lfsr[8], 2'h0, lfsr[1:0]};
      if (i == 0) d[23:0] = 24'h000010;
      if (i == 1) d[23:0] = 24'h020f00;
      a = (i == 3) ? 8'hd3 : (i == 5) ? {lfsr[31:25], 1'b1} : SLAVE_ADDR;
      send_frame(a, d);
      if (a == SLAVE_ADDR) cfg = d;
      check_cfg(cfg);
    end
    send_frame(SLAVE_ADDR, 48'h000000010f00);
    send_frame(SLAVE_ADDR, 48'h000000000511);
    check_cfg(48'h000000000511);
    report_and_stop();
  end
endmodule
